/* File: common/loop_cfg_pkg.sv */
/*
  Package for the optical power loop configuration register bank:
  register offsets, reset values, field positions and the per-channel
  configuration carrier. Assumes 8-bit registers on an 8-bit address.
*/
package loop_cfg_pkg;

  localparam int          NUM_CH          = 3;
  localparam int          TARGET_W        = 13;
  localparam int          REG_COUNT       = 13;

  // register offsets
  localparam logic [7:0]  LOOP_CONTROL_OFS          = 8'h34;
  localparam logic [7:0]  CH2_TARGET_HIGH_OFS       = 8'h35;
  localparam logic [7:0]  CH2_TARGET_LOW_OFS        = 8'h36;
  localparam logic [7:0]  CH1_TARGET_HIGH_OFS       = 8'h37;
  localparam logic [7:0]  CH1_TARGET_LOW_OFS        = 8'h38;
  localparam logic [7:0]  CH0_TARGET_HIGH_OFS       = 8'h39;
  localparam logic [7:0]  CH0_TARGET_LOW_OFS        = 8'h3a;
  localparam logic [7:0]  CH2_LOWPOWER_TGT_HIGH_OFS = 8'h3b;
  localparam logic [7:0]  CH2_LOWPOWER_TGT_LOW_OFS  = 8'h3c;
  localparam logic [7:0]  CH1_LOWPOWER_TGT_HIGH_OFS = 8'h3d;
  localparam logic [7:0]  CH1_LOWPOWER_TGT_LOW_OFS  = 8'h3e;
  localparam logic [7:0]  CH0_LOWPOWER_TGT_HIGH_OFS = 8'h3f;
  localparam logic [7:0]  CH0_LOWPOWER_TGT_LOW_OFS  = 8'h40;

  // reset values and masks
  localparam logic [7:0]  LOOP_CONTROL_RESET = 8'h7f;
  localparam logic [7:0]  TARGET_RESET       = 8'h00;
  localparam logic [7:0]  TARGET_HIGH_MASK   = 8'h1f;
  localparam logic [7:0]  FULL_MASK          = 8'hff;
  localparam logic [7:0]  UNMAPPED_DATA      = 8'h00;

  // loop_control fields
  localparam int          CLK_SEL_BIT    = 7;
  localparam int          LOOP_TYPE_BIT  = 6;
  localparam int          SEL_W          = 2;
  localparam logic [1:0]  SEL_DISABLE    = 2'h3;

  // target high part width
  localparam int          TGT_HIGH_W     = 5;

  typedef struct packed {
    logic                  loop_en;
    logic [1:0]            sense_sel;
    logic [TARGET_W-1:0]   target;
  } channel_cfg_t;

endpackage

/* File: rtl/loop_cfg_regs.sv */
/*
  Configuration register bank for the three-channel optical power loop:
  loop clock and type select, sense input routing, normal and low power
  targets. Assumes a serial host port front end has already decoded each
  access into an address, a write strobe with data and a read strobe, all
  synchronous to CORE_CLK.
*/
`timescale 1ns/1ps

//Contract
//- clock select bit 1 runs loop from line clock, 0 from internal oscillator.
//- loop type bit 1 selects continuous loop, 0 integrating loop.
//- per channel 2-bit sense select at bits 5:4, 3:2, 1:0; codes pick input 0..2.
//- sense select code 11 disables power control for that channel.
//- normal target is 13 bits: high register bits 4:0, low register 7:0.
//- low power target set replaces normal set while low power pin is low.
module loop_cfg_regs
  import loop_cfg_pkg::*;
#(
  parameter int SENSE_W = 10
) (
  // clock and reset
  input  wire logic                       CORE_CLK,
  input  wire logic                       RSTN,
  // decoded host port access
  input  wire logic [7:0]                 REG_ADDR,
  input  wire logic                       REG_WR,
  input  wire logic [7:0]                 REG_WDATA,
  input  wire logic                       REG_RD,
  output logic      [7:0]                 REG_RDATA,
  output logic                            REG_RVALID,
  // loop clock sources and low power select pin
  input  wire logic                       LINE_CLK_IN,
  input  wire logic                       OSC_CLK_IN,
  input  wire logic                       LOW_POWER_SELECT_PIN,
  // photodiode sense inputs
  input  wire logic [NUM_CH-1:0][SENSE_W-1:0] SENSE_INPUT,
  // loop configuration outputs
  output logic                            LOOP_CLK,
  output logic                            LOOP_CLK_EXTERNAL,
  output logic                            LOOP_CONTINUOUS,
  output channel_cfg_t [NUM_CH-1:0]       CH_CFG,
  output logic      [NUM_CH-1:0][SENSE_W-1:0] CH_SENSE
);

  logic [7:0]                  regs_reg  [REG_COUNT];
  logic [7:0]                  regs_next [REG_COUNT];
  logic [7:0]                  rdata_reg;
  logic [7:0]                  rdata_next;
  logic                        rvalid_reg;
  logic                        rvalid_next;
  logic                        loop_clk_reg;
  logic                        loop_clk_next;
  logic                        clk_ext_reg;
  logic                        clk_ext_next;
  logic                        cont_reg;
  logic                        cont_next;
  channel_cfg_t [NUM_CH-1:0]   cfg_reg;
  channel_cfg_t [NUM_CH-1:0]   cfg_next;
  logic [NUM_CH-1:0][SENSE_W-1:0] sense_reg;
  logic [NUM_CH-1:0][SENSE_W-1:0] sense_next;

  logic [7:0]                  idx;
  logic                        hit;

  assign idx = REG_ADDR - LOOP_CONTROL_OFS;
  assign hit = (REG_ADDR >= LOOP_CONTROL_OFS) && (REG_ADDR <= CH0_LOWPOWER_TGT_LOW_OFS);

  // odd indices are the high target registers with three reserved bits
  function automatic logic [7:0] wmask(input int i);
    if (i == 0) begin
      return FULL_MASK;
    end else if (i % 2 == 1) begin
      return TARGET_HIGH_MASK;
    end else begin
      return FULL_MASK;
    end
  endfunction

  // register writes and reads
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_next[i] = regs_reg[i];
      if (REG_WR && hit && (idx == 8'(i))) begin
        regs_next[i] = REG_WDATA & wmask(i);
      end
    end
    rvalid_next = REG_RD;
    rdata_next  = rdata_reg;
    if (REG_RD) begin
      rdata_next = hit ? regs_reg[idx[3:0]] : UNMAPPED_DATA;
    end
  end

  // derived loop configuration
  always_comb begin
    logic [1:0]          sel;
    int                  hi_n;
    int                  hi_lp;
    logic [TARGET_W-1:0] tgt_n;
    logic [TARGET_W-1:0] tgt_lp;
    sel    = 2'h0;
    hi_n   = 0;
    hi_lp  = 0;
    tgt_n  = '0;
    tgt_lp = '0;
    clk_ext_next = regs_reg[0][CLK_SEL_BIT];
    loop_clk_next = clk_ext_next ? LINE_CLK_IN : OSC_CLK_IN;
    cont_next = regs_reg[0][LOOP_TYPE_BIT];
    for (int c = 0; c < NUM_CH; c++) begin
      sel = regs_reg[0][c*SEL_W +: SEL_W];
      cfg_next[c].sense_sel = sel;
      cfg_next[c].loop_en   = (sel != SEL_DISABLE);
      sense_next[c] = '0;
      case (sel)
        2'h0: sense_next[c] = SENSE_INPUT[0];
        2'h1: sense_next[c] = SENSE_INPUT[1];
        2'h2: sense_next[c] = SENSE_INPUT[2];
        default: sense_next[c] = '0;
      endcase
      // channel 2 sits first in each target group
      hi_n  = 1 + 2 * (NUM_CH - 1 - c);
      hi_lp = hi_n + 2 * NUM_CH;
      tgt_n  = {regs_reg[hi_n][TGT_HIGH_W-1:0], regs_reg[hi_n + 1]};
      tgt_lp = {regs_reg[hi_lp][TGT_HIGH_W-1:0], regs_reg[hi_lp + 1]};
      cfg_next[c].target = LOW_POWER_SELECT_PIN ? tgt_n : tgt_lp;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      regs_reg[0] <= LOOP_CONTROL_RESET;
      for (int i = 1; i < REG_COUNT; i++) begin
        regs_reg[i] <= TARGET_RESET;
      end
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
      loop_clk_reg <= 1'b0;
      // derived outputs match the reset control value, so no step follows release
      clk_ext_reg  <= LOOP_CONTROL_RESET[CLK_SEL_BIT];
      cont_reg     <= LOOP_CONTROL_RESET[LOOP_TYPE_BIT];
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_reg[c].loop_en   <= 1'b0;
        cfg_reg[c].sense_sel <= SEL_DISABLE;
        cfg_reg[c].target    <= '0;
      end
      sense_reg    <= '0;
    end else begin
      regs_reg     <= regs_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      loop_clk_reg <= loop_clk_next;
      clk_ext_reg  <= clk_ext_next;
      cont_reg     <= cont_next;
      cfg_reg      <= cfg_next;
      sense_reg    <= sense_next;
    end
  end

  assign REG_RDATA         = rdata_reg;
  assign REG_RVALID        = rvalid_reg;
  assign LOOP_CLK          = loop_clk_reg;
  assign LOOP_CLK_EXTERNAL = clk_ext_reg;
  assign LOOP_CONTINUOUS   = cont_reg;
  assign CH_CFG            = cfg_reg;
  assign CH_SENSE          = sense_reg;

endmodule // loop_cfg_regs

/* File: dv/loop_cfg_regs_properties.sv */
/* Checker for loop_cfg_regs port timing.
   Assumes it is bound to loop_cfg_regs and sees only its ports. */
`timescale 1ns/1ps
module loop_cfg_regs_properties
  import loop_cfg_pkg::*;
#(parameter int SENSE_W = 10) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // loop side
  input wire logic LINE_CLK_IN,
  input wire logic OSC_CLK_IN,
  input wire logic LOW_POWER_SELECT_PIN,
  input wire logic [NUM_CH-1:0][SENSE_W-1:0] SENSE_INPUT,
  input wire logic LOOP_CLK,
  input wire logic LOOP_CLK_EXTERNAL,
  input wire logic LOOP_CONTINUOUS,
  input wire channel_cfg_t [NUM_CH-1:0] CH_CFG,
  input wire logic [NUM_CH-1:0][SENSE_W-1:0] CH_SENSE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // sense values one edge back, to match the registered routing
  logic [NUM_CH-1:0][SENSE_W-1:0] sense_d;
  always_ff @(posedge CORE_CLK) sense_d <= SENSE_INPUT;
  wire ctl_wr = REG_WR && REG_ADDR == LOOP_CONTROL_OFS;
  wire hi_rd = REG_RD && REG_ADDR inside {8'h35, 8'h37, 8'h39, 8'h3b, 8'h3d, 8'h3f};
  wire off_rd = REG_RD && (REG_ADDR < 8'h34 || REG_ADDR > 8'h40);
  sequence rd_answer; ##1 REG_RVALID; endsequence
  sequence ctl_settled; ##2 1'b1; endsequence
  a_read_answer: assert property (REG_RD |-> rd_answer)
    else $error("read not answered");
  a_reserved_zero: assert property (hi_rd |=> REG_RDATA[7:5] == 3'h0)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (off_rd |=> REG_RDATA == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  a_ctrl_apply: assert property (ctl_wr |-> ctl_settled ##0
    {LOOP_CLK_EXTERNAL, LOOP_CONTINUOUS} == $past(REG_WDATA[7:6], 2)) else $error("ctrl lost");
  a_ctrl_hold: assert property (!ctl_wr |-> ##2
    $stable({LOOP_CLK_EXTERNAL, LOOP_CONTINUOUS})) else $error("ctrl moved");
  a_clk_source: assert property (LOOP_CLK ==
    (LOOP_CLK_EXTERNAL ? $past(LINE_CLK_IN) : $past(OSC_CLK_IN))) else $error("bad clock");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_route_sense: assert property (CH_CFG[i].loop_en |->
      CH_SENSE[i] == sense_d[CH_CFG[i].sense_sel]) else $error("bad routing");
    a_disable_code: assert property (CH_CFG[i].loop_en == (CH_CFG[i].sense_sel != SEL_DISABLE)
      && (CH_CFG[i].loop_en || CH_SENSE[i] == '0)) else $error("bad disable");
  end
endmodule // loop_cfg_regs_properties
bind loop_cfg_regs loop_cfg_regs_properties #(.SENSE_W(SENSE_W)) loop_cfg_regs_properties_inst (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .LINE_CLK_IN(LINE_CLK_IN), .OSC_CLK_IN(OSC_CLK_IN), .SENSE_INPUT(SENSE_INPUT),
  .LOW_POWER_SELECT_PIN(LOW_POWER_SELECT_PIN), .LOOP_CLK(LOOP_CLK), .CH_CFG(CH_CFG),
  .LOOP_CLK_EXTERNAL(LOOP_CLK_EXTERNAL), .LOOP_CONTINUOUS(LOOP_CONTINUOUS), .CH_SENSE(CH_SENSE));

/* File: dv/tb_top.sv */
/* Self-checking bench for loop_cfg_regs: register reads and writes,
   routing and target selection. Assumes the checker is bound separately. */
`timescale 1ns/1ps
module tb_top
  import loop_cfg_pkg::*;
;
  logic CORE_CLK = 0, RSTN = 0, REG_WR = 0, REG_RD = 0, LINE_CLK_IN = 0, OSC_CLK_IN = 0;
  logic LOW_POWER_SELECT_PIN = 1, REG_RVALID, LOOP_CLK, LOOP_CLK_EXTERNAL, LOOP_CONTINUOUS;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [NUM_CH-1:0][9:0] SENSE_INPUT = '0, CH_SENSE;
  channel_cfg_t [NUM_CH-1:0] CH_CFG;
  logic [7:0] ctl [2] = '{8'hd2, 8'h27};
  int miscompares = 0, comparisons = 0;
  logic line_q = 0, osc_q = 0;
  // source levels as the design sampled them at the last rising edge
  always @(posedge CORE_CLK) {line_q, osc_q} <= {LINE_CLK_IN, OSC_CLK_IN};
  loop_cfg_regs #(.SENSE_W(10)) loop_cfg_regs_inst (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LINE_CLK_IN(LINE_CLK_IN),
    .OSC_CLK_IN(OSC_CLK_IN), .LOW_POWER_SELECT_PIN(LOW_POWER_SELECT_PIN), .CH_CFG(CH_CFG),
    .SENSE_INPUT(SENSE_INPUT), .LOOP_CLK(LOOP_CLK), .LOOP_CLK_EXTERNAL(LOOP_CLK_EXTERNAL),
    .LOOP_CONTINUOUS(LOOP_CONTINUOUS), .CH_SENSE(CH_SENSE));
  always #5 CORE_CLK = ~CORE_CLK;
  // two unequal clock sources so a wrong select shows
  always @(negedge CORE_CLK) LINE_CLK_IN <= ~LINE_CLK_IN;
  always @(negedge CORE_CLK) if (LINE_CLK_IN) OSC_CLK_IN <= ~OSC_CLK_IN;
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CORE_CLK);
    {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
    @(negedge CORE_CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(negedge CORE_CLK);
    {REG_ADDR, REG_RD} = {a, 1'b1};
    @(negedge CORE_CLK);
    REG_RD = 1'b0;
    for (n = 0; n < 4 && REG_RVALID !== 1'b1; n++) @(negedge CORE_CLK);
    if (n == 4) begin
      miscompares++;
      results();
    end
    chk({8'h00, REG_RDATA}, {8'h00, exp});
  endtask
  // data written to offset o is o ^ f0, so each byte is distinct
  function automatic logic [15:0] tgt(input logic [7:0] o);
    return {3'h0, 5'(o ^ 8'hf0), 8'(o + 8'h01) ^ 8'hf0};
  endfunction
  initial begin
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RSTN = 1'b1;
    for (int a = 8'h33; a <= 8'h41; a++) rd(8'(a), a == 8'h34 ? 8'h7f : 8'h00);
    for (int a = 8'h35; a <= 8'h40; a++) wr(8'(a), 8'(a) ^ 8'hf0);
    for (int a = 8'h35; a <= 8'h40; a++) rd(8'(a), (8'(a) ^ 8'hf0) & (a[0] ? 8'h1f : 8'hff));
    for (int c = 0; c < NUM_CH; c++) chk(16'(CH_CFG[c].target), tgt(8'h39 - 8'(2 * c)));
    LOW_POWER_SELECT_PIN = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    for (int c = 0; c < NUM_CH; c++) chk(16'(CH_CFG[c].target), tgt(8'h3f - 8'(2 * c)));
    SENSE_INPUT = {10'h333, 10'h222, 10'h111};
    foreach (ctl[k]) begin
      wr(LOOP_CONTROL_OFS, ctl[k]);
      repeat (2) @(negedge CORE_CLK);
      chk(16'({LOOP_CLK_EXTERNAL, LOOP_CONTINUOUS}), 16'(ctl[k][7:6]));
      chk(16'(LOOP_CLK), 16'(ctl[k][7] ? line_q : osc_q));
      for (int c = 0; c < NUM_CH; c++) chk(16'({CH_CFG[c].loop_en, CH_SENSE[c]}),
        16'(ctl[k][2*c+:2] == SEL_DISABLE ? 11'h0 : {1'b1, SENSE_INPUT[ctl[k][2*c+:2]]}));
    end
    results();
  end
endmodule // tb_top
